// *** verilog/sfs_cycle_ctrl.sv ***
// cycle control and storage of a synchronous flow-through burst sram
// assumes all pins except reset, sleep and output drive are synchronous to the clock
// the data bus is split into input, output and output enable signals
// memory contents survive reset; unwritten words read back as unknowns
`timescale 1ns/1ns
// Operation
// - all selects active, load low, write strobe high starts a read burst.
// - load high during a read burst reads the next burst address.
// - reads with output drive inactive advance addresses but leave the bus floating.
// - all selects, load low, strobe low, a lane low starts a write burst.
// - load high during a write burst writes the next burst address.
// - write start with both lanes deselected stores nothing, bus floats.
// - continued write with both lanes deselected advances without writing.
// - clock qualifier high makes the edge ignored, state held.
// - any write cycle floats all data and parity pins.
// - pin drive follows the current cycle type and output drive input.
// - output drive acts combinationally and is masked during writes.
// - read data driven only while output drive is active and selected.
// - after reset the device is deselected and the bus floats.
// - write data is captured at the edge after its address cycle.
// - only lanes whose select is low are written.
// - burst order linear or interleaved on two low bits, wrapping after four.
// - sleep floats the bus and makes all other inputs except reset ignored.
module sfs_cycle_ctrl
    import sfs_pkg::*;
(
    // clock and reset
    input  wire logic              CLOCK_IN,
    input  wire logic              RST_N_IN,
    // address and selects
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic              CHIP_SEL_A_N_IN,
    input  wire logic              CHIP_SEL_B_IN,
    input  wire logic              CHIP_SEL_C_N_IN,
    // cycle control
    input  wire logic              ADVANCE_OR_LOAD_IN,
    input  wire logic              WRITE_STROBE_N_IN,
    input  wire logic              LANE_A_WRITE_SEL_N_IN,
    input  wire logic              LANE_B_WRITE_SEL_N_IN,
    input  wire logic              CLOCK_QUALIFY_N_IN,
    input  wire logic              SLEEP_REQUEST_IN,
    input  wire logic              OUTPUT_DRIVE_EN_N_IN,
    input  wire logic              BURST_ORDER_IN,
    // common data bus, split
    input  wire logic [DATA_W-1:0] DATA_IN,
    input  wire logic [PAR_W-1:0]  PARITY_LANE_IN,
    output logic      [DATA_W-1:0] DATA_OUT,
    output logic      [PAR_W-1:0]  PARITY_LANE_OUT,
    output logic                   DATA_OE_OUT
);

    // storage, not reset: contents survive reset and sleep
    logic [WORD_W-1:0]    mem_array [0:MEM_DEPTH-1];

    // cycle type, latched lanes and read word
    sfs_cycle_e           mode_q;
    sfs_cycle_e           mode_d;
    logic [UPPER_W-1:0]   upper_q;
    logic [NUM_LANES-1:0] lanes_n_q;
    logic [NUM_LANES-1:0] lanes_n_pin;
    logic [WORD_W-1:0]    rd_q;

    // edge qualification and burst control
    logic                 qualified;
    logic                 selected;
    logic                 load;
    logic                 step;
    logic                 commit;

    // address path
    logic [BURST_W-1:0]   cur_low;
    logic [BURST_W-1:0]   nxt_low;
    logic [ADDR_W-1:0]    cur_addr;
    logic [ADDR_W-1:0]    next_addr;

    // write merge path
    logic [WORD_W-1:0]    in_word;
    logic [WORD_W-1:0]    old_word;
    logic [WORD_W-1:0]    merged_word;

    // a stalled or sleeping edge moves nothing but the sleep drop
    // qualifier high ignores edge
    assign qualified   = !CLOCK_QUALIFY_N_IN && !SLEEP_REQUEST_IN;
    assign selected    = !CHIP_SEL_A_N_IN && CHIP_SEL_B_IN && !CHIP_SEL_C_N_IN;
    assign lanes_n_pin = {LANE_B_WRITE_SEL_N_IN, LANE_A_WRITE_SEL_N_IN};

    // address load on every qualified load edge, step only inside a burst
    // a deselect load moves the counter too; nothing reads it until the next load
    assign load = qualified && !ADVANCE_OR_LOAD_IN;
    assign step = qualified && ADVANCE_OR_LOAD_IN && (mode_q != CYC_DESEL);

    // burst sequencer for the two low address bits
    // order is used live, so it must stay still for a whole burst
    sfs_burst_ctr u_burst (
        .clk_in      (CLOCK_IN),
        .rst_n_in    (RST_N_IN),
        .load_in     (load),
        .step_in     (step),
        .load_low_in (ADDR_IN[BURST_W-1:0]),
        .order_in    (BURST_ORDER_IN),
        .cur_low_out (cur_low),
        .nxt_low_out (nxt_low)
    );

    // address of the current cycle and of the one the coming edge starts
    assign cur_addr  = {upper_q, cur_low};
    assign next_addr = load ? ADDR_IN : {upper_q, nxt_low};

    // cycle decode at a qualified edge
    // applied only at qualified edges; sleep overrides it in the register
    always_comb begin
        mode_d = mode_q;
        if (!ADVANCE_OR_LOAD_IN) begin
            if (!selected) begin
                mode_d = CYC_DESEL;
            end else if (WRITE_STROBE_N_IN) begin
                mode_d = CYC_READ;
            end else begin
                mode_d = CYC_WRITE;
            end
        end
        // load high keeps the latched type, deselect included
    end

    // sleep is acted on at edges here; the bus floats at once further down
    // reset deselects
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_q <= CYC_DESEL;
        end else if (SLEEP_REQUEST_IN) begin
            // pending accesses are dropped on the way into sleep
            mode_q <= CYC_DESEL;
        end else if (qualified) begin
            mode_q <= mode_d;
        end
    end

    // upper address bits taken at a load edge
    // a deselect load updates them as well, harmless as nothing reads them then
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            upper_q <= RST_UPPER;
        end else if (load) begin
            upper_q <= ADDR_IN[ADDR_W-1:BURST_W];
        end
    end

    // a stall holds the lanes, so the data phase waits for the next qualified edge
    // lanes taken every write cycle
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lanes_n_q <= LANES_NONE;
        end else if (SLEEP_REQUEST_IN) begin
            lanes_n_q <= LANES_NONE;
        end else if (qualified) begin
            lanes_n_q <= (mode_d == CYC_WRITE) ? lanes_n_pin : LANES_NONE;
        end
    end

    // the pending write commits at the first qualified edge after its address
    // data taken edge after address
    assign commit = qualified && (mode_q == CYC_WRITE) && (lanes_n_q != LANES_NONE);

    // word being written over; read before the edge that commits
    assign old_word = mem_array[cur_addr];

    // per-lane packing: lane a in the low half, lane b in the high half
    // each stored lane is its parity bit above its data byte
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
        // bus pins of this lane gathered into the stored word
        assign in_word[l*LANE_W +: LANE_W] = {PARITY_LANE_IN[l], DATA_IN[l*LANE_DW +: LANE_DW]};
        assign merged_word[l*LANE_W +: LANE_W] = lanes_n_q[l] ? old_word[l*LANE_W +: LANE_W]
                                                              : in_word[l*LANE_W +: LANE_W];
        // read word back onto this lane's pins, shown even while the bus floats
        assign DATA_OUT[l*LANE_DW +: LANE_DW] = rd_q[l*LANE_W +: LANE_DW];
        assign PARITY_LANE_OUT[l]             = rd_q[l*LANE_W + LANE_DW];
    end

    // self-timed write of the merged word
    // the array has no reset, so a reset in mid-burst cannot corrupt a word
    always_ff @(posedge CLOCK_IN) begin
        if (commit) begin
            mem_array[cur_addr] <= merged_word;
        end
    end

    // the next address is formed before the edge, so the word flows through at once
    // read the next address
    // dummy reads fetch as well
    // a write finishing on the same edge is forwarded so the read sees it
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_q <= RST_WORD;
        end else if (qualified && (mode_d == CYC_READ)) begin
            if (commit && (next_addr == cur_addr)) begin
                rd_q <= merged_word;
            end else begin
                rd_q <= mem_array[next_addr];
            end
        end
    end

    // a write start or deselect drops the drive at its edge, as mode_q leaves read
    // write cycles float the bus
    // sleep floats at once
    // the enable is not registered so the bus turns around within the cycle
    assign DATA_OE_OUT = (mode_q == CYC_READ) && !OUTPUT_DRIVE_EN_N_IN && !SLEEP_REQUEST_IN;

endmodule : sfs_cycle_ctrl

// *** verilog/sfs_pkg.sv ***
// shared constants and types of the flow-through burst sram cycle control
// assumes one clock domain and an active-low asynchronous reset in every user
package sfs_pkg;

    // array geometry: 128k words of two 9-bit lanes (8 data bits plus parity)
    localparam int unsigned ADDR_W    = 17;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned PAR_W     = 2;
    localparam int unsigned LANE_W    = 9;
    localparam int unsigned LANE_DW   = 8;
    localparam int unsigned NUM_LANES = 2;
    localparam int unsigned WORD_W    = LANE_W * NUM_LANES;
    localparam int unsigned MEM_DEPTH = 1 << ADDR_W;

    // burst counter covers the two low address bits
    localparam int unsigned BURST_W   = 2;
    localparam int unsigned UPPER_W   = ADDR_W - BURST_W;

    // lane select pattern meaning no lane is written
    localparam logic [NUM_LANES-1:0] LANES_NONE = 2'h3;

    // values after reset
    localparam logic [BURST_W-1:0]   RST_BURST = 2'h0;
    localparam logic [UPPER_W-1:0]   RST_UPPER = 15'h0000;
    localparam logic [WORD_W-1:0]    RST_WORD  = 18'h00000;

    // cycle type held between qualified edges
    typedef enum logic [1:0] {
        CYC_DESEL,
        CYC_READ,
        CYC_WRITE
    } sfs_cycle_e;

endpackage : sfs_pkg

// *** verilog/sfs_burst_ctr.sv ***
// two-bit burst address sequencer, linear or interleaved order
// assumes load and step are never high together and come from qualified edges
`timescale 1ns/1ns
module sfs_burst_ctr
    import sfs_pkg::*;
(
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // control
    input  wire logic               load_in,
    input  wire logic               step_in,
    input  wire logic [BURST_W-1:0] load_low_in,
    input  wire logic               order_in,
    // sequenced low address bits
    output logic      [BURST_W-1:0] cur_low_out,
    output logic      [BURST_W-1:0] nxt_low_out
);

    logic [BURST_W-1:0] base_q;
    logic [BURST_W-1:0] cnt_q;
    logic [BURST_W-1:0] cnt_inc;

    // start address and access count; count wraps after four accesses
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            base_q <= RST_BURST;
            cnt_q  <= RST_BURST;
        end else if (load_in) begin
            base_q <= load_low_in;
            cnt_q  <= RST_BURST;
        end else if (step_in) begin
            cnt_q <= cnt_inc;
        end
    end

    always_comb begin
        cnt_inc = cnt_q + 2'h1;
        if (order_in) begin
            cur_low_out = base_q ^ cnt_q;
            nxt_low_out = base_q ^ cnt_inc;
        end else begin
            cur_low_out = base_q + cnt_q;
            nxt_low_out = base_q + cnt_inc;
        end
    end

endmodule : sfs_burst_ctr

// *** dv/sfs_cycle_ctrl_sva.sv ***
// pin-level assertions of the sram cycle control
// assumes binding to sfs_cycle_ctrl in its single clock domain
`timescale 1ns/1ns
module sfs_cycle_ctrl_sva
    import sfs_pkg::*;
(
    // clock and reset
    input wire logic              CLOCK_IN,
    input wire logic              RST_N_IN,
    // cycle control
    input wire logic              CHIP_SEL_A_N_IN,
    input wire logic              CHIP_SEL_B_IN,
    input wire logic              CHIP_SEL_C_N_IN,
    input wire logic              ADVANCE_OR_LOAD_IN,
    input wire logic              WRITE_STROBE_N_IN,
    input wire logic              CLOCK_QUALIFY_N_IN,
    input wire logic              SLEEP_REQUEST_IN,
    input wire logic              OUTPUT_DRIVE_EN_N_IN,
    // bus side
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic [PAR_W-1:0]  PARITY_LANE_OUT,
    input wire logic              DATA_OE_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire qual = !CLOCK_QUALIFY_N_IN && !SLEEP_REQUEST_IN;
    wire sel  = !CHIP_SEL_A_N_IN && CHIP_SEL_B_IN && !CHIP_SEL_C_N_IN;
    // load and continue steps at qualified edges
    sequence rd_load; qual && !ADVANCE_OR_LOAD_IN && sel && WRITE_STROBE_N_IN; endsequence
    sequence wr_load; qual && !ADVANCE_OR_LOAD_IN && sel && !WRITE_STROBE_N_IN; endsequence
    sequence rd_cont; qual && ADVANCE_OR_LOAD_IN && DATA_OE_OUT; endsequence
    sequence en_now; !OUTPUT_DRIVE_EN_N_IN && !SLEEP_REQUEST_IN; endsequence

    a_read_drives: assert property (rd_load ##1 en_now |-> DATA_OE_OUT)
        else $error("read start left the bus floating");
    a_read_continues: assert property (rd_cont ##1 en_now |-> DATA_OE_OUT)
        else $error("read continue left the bus floating");
    a_write_floats: assert property (wr_load |=> !DATA_OE_OUT)
        else $error("bus driven after a write start");
    a_write_cont_off: assert property (wr_load ##1 (qual && ADVANCE_OR_LOAD_IN)
                                       |=> !DATA_OE_OUT)
        else $error("bus driven during a write continue");
    a_desel_floats: assert property (qual && !ADVANCE_OR_LOAD_IN && !sel
                                     |=> !DATA_OE_OUT)
        else $error("bus driven after a deselect");
    a_enable_gates: assert property (OUTPUT_DRIVE_EN_N_IN || SLEEP_REQUEST_IN
                                     |-> !DATA_OE_OUT)
        else $error("bus driven without output drive or in sleep");
    a_stall_holds: assert property (CLOCK_QUALIFY_N_IN && !SLEEP_REQUEST_IN |=>
                                    $stable({DATA_OUT, PARITY_LANE_OUT}))
        else $error("read word changed on an ignored edge");
    a_stall_keeps_oe: assert property (CLOCK_QUALIFY_N_IN && !SLEEP_REQUEST_IN ##1
        ($stable(OUTPUT_DRIVE_EN_N_IN) && !SLEEP_REQUEST_IN) |-> $stable(DATA_OE_OUT))
        else $error("drive state changed on an ignored edge");
    a_reset_floats: assert property ($rose(RST_N_IN) |-> !DATA_OE_OUT)
        else $error("bus driven right after reset");
endmodule : sfs_cycle_ctrl_sva

bind sfs_cycle_ctrl sfs_cycle_ctrl_sva u_sva (
    .CLOCK_IN, .RST_N_IN, .CHIP_SEL_A_N_IN, .CHIP_SEL_B_IN, .CHIP_SEL_C_N_IN,
    .ADVANCE_OR_LOAD_IN, .WRITE_STROBE_N_IN, .CLOCK_QUALIFY_N_IN, .SLEEP_REQUEST_IN,
    .OUTPUT_DRIVE_EN_N_IN, .DATA_OUT, .PARITY_LANE_OUT, .DATA_OE_OUT
);

// *** dv/sfs_ctl_model.sv ***
// memory controller model: drives the pins, keeps a 16-word reference window
// assumes step is called once a clock, 1 ns after the rising edge
`timescale 1ns/1ns
module sfs_ctl_model
    import sfs_pkg::*;
(
    // clock
    input  wire logic              clk_in,
    // {order, oe_n, sleep, cqn, lane b_n, lane a_n, we_n, adv, sel c_n, b, a_n}
    output logic      [10:0]       ctl_out,
    // address and bus word {parity, data}
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [WORD_W-1:0] word_out
);
    logic [WORD_W-1:0] ref_mem [16];
    logic [WORD_W-1:0] exp_q [$];
    sfs_cycle_e        mode_m = CYC_DESEL;
    logic [ADDR_W-1:0] base_m, cur_a, pend_a;
    logic [1:0]        cnt_m, lanes_m;
    logic              pend_m = 1'b0;

    // deselected at time zero, drive requested so a stray drive shows
    initial begin
        ctl_out = 11'h061;
        addr_out = 17'h0;
        word_out = 18'h0;
    end

    // one bus cycle; the values set here are taken at the coming edge
    task automatic step(input logic [9:0] c, input logic [3:0] a, input logic ord);
        logic [WORD_W-1:0] w, m;
        w = WORD_W'($urandom);
        m = {~lanes_m[1], ~lanes_m[0], {8{~lanes_m[1]}}, {8{~lanes_m[0]}}};
        ctl_out = {ord, c};
        addr_out = ADDR_W'(a);
        word_out = w; // noise, a fresh random word, unless a data phase is due
        // the word on the bus now answers the edge just passed
        if (mode_m == CYC_READ && !c[9] && !c[8]) exp_q.push_back(ref_mem[cur_a[3:0]]);
        if (c[8]) begin
            mode_m = CYC_DESEL;
            pend_m = 1'b0;
        end else if (!c[7]) begin
            if (pend_m) ref_mem[pend_a[3:0]] = (ref_mem[pend_a[3:0]] & ~m) | (w & m);
            if (!c[3]) begin
                base_m = ADDR_W'(a);
                cnt_m = 2'h0;
                mode_m = (c[2:0] != 3'b010) ? CYC_DESEL : c[4] ? CYC_READ : CYC_WRITE;
            end else if (mode_m != CYC_DESEL) cnt_m = cnt_m + 2'h1;
            cur_a = {base_m[ADDR_W-1:BURST_W],
                     ord ? base_m[1:0] ^ cnt_m : base_m[1:0] + cnt_m};
            pend_m = (mode_m == CYC_WRITE);
            pend_a = cur_a;
            lanes_m = c[6:5];
        end
        @(posedge clk_in);
        #1;
    endtask : step
endmodule : sfs_ctl_model

// *** dv/test_sync_flowthrough_sram_cycle_control.sv ***
// self-checking bench: controller model drives the block, bus words compared
// assumes the checker binds itself; expectations are noted by the model
`timescale 1ns/1ns
module test_sync_flowthrough_sram_cycle_control;
    import sfs_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [10:0]       ctl;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wd;
    logic [DATA_W-1:0] dout;
    logic [PAR_W-1:0]  pout;
    logic              oe;
    logic [31:0]       r;
    int                error_cnt = 0;
    int                cmp_count = 0;

    // 100 MHz clock
    initial forever #5 clk = ~clk;

    sfs_ctl_model ctl_m (.clk_in(clk), .ctl_out(ctl), .addr_out(addr), .word_out(wd));
    sfs_cycle_ctrl dut (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
        .CHIP_SEL_A_N_IN(ctl[0]), .CHIP_SEL_B_IN(ctl[1]), .CHIP_SEL_C_N_IN(ctl[2]),
        .ADVANCE_OR_LOAD_IN(ctl[3]), .WRITE_STROBE_N_IN(ctl[4]),
        .LANE_A_WRITE_SEL_N_IN(ctl[5]), .LANE_B_WRITE_SEL_N_IN(ctl[6]),
        .CLOCK_QUALIFY_N_IN(ctl[7]), .SLEEP_REQUEST_IN(ctl[8]),
        .OUTPUT_DRIVE_EN_N_IN(ctl[9]), .BURST_ORDER_IN(ctl[10]),
        .DATA_IN(wd[DATA_W-1:0]), .PARITY_LANE_IN(wd[WORD_W-1:DATA_W]),
        .DATA_OUT(dout), .PARITY_LANE_OUT(pout), .DATA_OE_OUT(oe)
    );

    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: bus word %h, expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: bus drive %b, expected %b", $time, got, exp);
        end
    endtask : cmp_flag

    // mid-cycle, once outputs settle: drive must match a pending note
    always @(negedge clk) begin
        cmp_flag(oe, ctl_m.exp_q.size() != 0);
        if (oe === 1'b1 && ctl_m.exp_q.size() != 0)
            cmp_word({pout, dout}, ctl_m.exp_q.pop_front());
        ctl_m.exp_q.delete(); // resync after a miss
    end

    // reset, fill the window, then for each order a read-back followed by random traffic
    initial begin
        void'($urandom(53051));
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 16; i++)
            ctl_m.step({6'h00, i % 4 != 0, 3'b010}, 4'(i & 12), 1'b0);
        for (int o = 0; o < 2; o++) begin
            for (int i = 0; i < 16; i++)
                ctl_m.step({6'h07, i % 4 != 0, 3'b010}, 4'(i & 12 | 1 + 2 * o), o[0]);
            for (int n = 0; n < 300; n++) begin
                r = $urandom;
                ctl_m.step({r[1:0] == 0, r[7:4] == 0, r[10:8] == 0, r[14:11],
                            r[15] ? 3'b010 : r[18:16]}, r[22:19], o[0]);
            end
        end
        complete_run();
    end

    // watchdog far beyond the roughly 650 cycles of traffic
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule : test_sync_flowthrough_sram_cycle_control
